// ==== common/spi_access_pkg.sv ====
// Constants, frame layouts and register defaults for the serial register port
package spi_access_pkg;

  localparam logic [3:0]  LAST_BIT_IDX       = 4'hF;
  localparam logic [3:0]  READ_PATTERN       = 4'hC;
  localparam logic [15:0] ERROR_FRAME        = 16'h8000;
  localparam logic [7:0]  ZERO_BYTE          = 8'h00;

  localparam logic [5:0]  ADDR_EN            = 6'h00;
  localparam logic [5:0]  ADDR_CONFIG_ONE    = 6'h01;
  localparam logic [5:0]  ADDR_FAULT_ONE     = 6'h11;
  localparam logic [5:0]  ADDR_FAULT_TWO     = 6'h12;
  localparam logic [5:0]  ADDR_LIMP_EN       = 6'h17;
  localparam logic [5:0]  ADDR_LAST          = 6'h24;
  localparam int          REG_COUNT          = 37;

  localparam int          LIMP_BIT           = 4;
  localparam int          RESISTOR_OPEN_BIT  = 7;
  localparam int          POWER_CYCLED_BIT   = 5;
  localparam int          THERMAL_WARN_BIT   = 4;
  localparam logic [7:0]  FAULT_ONE_SET_MASK = 8'h9F;
  localparam logic [7:0]  FAULT_TWO_SET_MASK = 8'hFF;

  localparam logic [7:0] REG_DEFAULT [0:REG_COUNT-1] = '{
    8'h3C, 8'h00, 8'h00, 8'h00, 8'h55, 8'h05, 8'h77, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h0A,
    8'h99, 8'h20, 8'h00, 8'h3C, 8'h0F, 8'h00, 8'h22, 8'h3C,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } link_state_t;

  typedef struct packed {
    logic       limp_pin;
    logic       mosi;
    logic       sclk;
    logic       slave_select_low;
  } pin_set_t;

  localparam pin_set_t PIN_IDLE = '{limp_pin: 1'b0, mosi: 1'b0, sclk: 1'b0, slave_select_low: 1'b1};

  typedef struct packed {
    logic       write;
    logic [5:0] addr;
    logic       odd_check_bit;
    logic [7:0] data;
  } command_frame_t;

  typedef struct packed {
    logic       serial_error_flag;
    logic [3:0] pattern;
    logic       timing_resistor_open_flag;
    logic       power_cycled_flag;
    logic       thermal_warning_flag;
    logic [7:0] data;
  } read_response_t;

  typedef struct packed {
    logic       serial_error_flag;
    logic       write;
    logic [5:0] addr;
    logic [7:0] data;
  } write_response_t;

endpackage

// ==== rtl/bit_synchronizer.sv ====
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module bit_synchronizer #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage1 <= RESET_VALUE;
      q_out  <= RESET_VALUE;
    end else begin
      stage1 <= d_in;
      q_out  <= stage1;
    end
  end

endmodule // bit_synchronizer

// ==== rtl/spi_register_access_port.sv ====
// Serial slave port giving a host access to the 8-bit configuration and status registers
`timescale 1ns/1ps
module spi_register_access_port (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       slave_select_low_in,
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       limp_home_pin_in,
  input  wire logic [7:0] fault_set_one_in,
  input  wire logic [7:0] fault_set_two_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  output logic            serial_error_flag_out,
  output logic            limp_home_status_out,
  output logic [7:0]      active_enable_out,
  output logic [1:0]      channel_enable_out
);

  spi_access_pkg::pin_set_t       raw_pins;
  spi_access_pkg::pin_set_t       pins;
  spi_access_pkg::link_state_t    state;
  spi_access_pkg::command_frame_t cmd;
  spi_access_pkg::read_response_t rd_resp;
  spi_access_pkg::write_response_t wr_resp;

  logic        prev_sel_low;
  logic        prev_sck;
  logic        sel_fall;
  logic        sel_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        decode_now;
  logic [3:0]  rise_count;
  logic        got_frame;
  logic [15:0] shift_reg;
  logic [15:0] response;
  logic        parity_bad;
  logic        aligned;
  logic        frame_err;
  logic        addr_listed;
  logic        do_write;
  logic        do_clear;
  logic [7:0]  rd_data;
  logic [7:0]  cmd_data;
  logic        mosi_s;
  logic        limp_pin_s;
  logic [15:0] next_response;
  logic [7:0]  next_config_one;
  logic [7:0]  next_fault_one;
  logic [7:0]  next_fault_two;
  logic [7:0]  regs [0:spi_access_pkg::REG_COUNT-1];

  assign raw_pins = '{limp_pin: limp_home_pin_in, mosi: mosi_in, sclk: sclk_in,
                      slave_select_low: slave_select_low_in};

  bit_synchronizer #(
    .WIDTH       (4),
    .RESET_VALUE (spi_access_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (raw_pins),
    .q_out  (pins)
  );

  assign mosi_s     = pins.mosi;
  assign limp_pin_s = pins.limp_pin;
  assign sel_fall   = prev_sel_low & ~pins.slave_select_low;
  assign sel_rise   = ~prev_sel_low & pins.slave_select_low;
  assign sck_rise   = (state == spi_access_pkg::ST_SHIFT) & ~prev_sck & pins.sclk & ~pins.slave_select_low;
  assign sck_fall   = (state == spi_access_pkg::ST_SHIFT) & prev_sck & ~pins.sclk & ~pins.slave_select_low;
  assign decode_now = (state == spi_access_pkg::ST_SHIFT) & sel_rise;

  // Edge history of synchronised pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_sel_low <= 1'b1;
      prev_sck     <= 1'b0;
    end else begin
      prev_sel_low <= pins.slave_select_low;
      prev_sck     <= pins.sclk;
    end
  end

  // Transfer framing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= spi_access_pkg::ST_IDLE;
    end else if (sel_fall) begin
      state <= spi_access_pkg::ST_SHIFT;
    end else if (sel_rise) begin
      state <= spi_access_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rise_count <= 4'h0;
      got_frame  <= 1'b0;
    end else if (sel_fall) begin
      rise_count <= 4'h0;
      got_frame  <= 1'b0;
    end else if (sck_rise) begin
      rise_count <= 4'(rise_count + 4'h1);
      if (rise_count == spi_access_pkg::LAST_BIT_IDX) begin
        got_frame <= 1'b1;
      end
    end
  end

  // One register both receives and transmits, so extra clocks flow through
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_reg <= spi_access_pkg::ERROR_FRAME;
    end else if (sel_fall) begin
      shift_reg <= response;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[14:0], mosi_s};
    end
  end

  // Open-drain output: enable only while pulling low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      miso_out    <= 1'b1;
      miso_oe_out <= 1'b0;
    end else if (sel_fall) begin
      miso_out    <= response[15];
      miso_oe_out <= ~response[15];
    end else if (sel_rise || pins.slave_select_low) begin
      miso_out    <= 1'b1;
      miso_oe_out <= 1'b0;
    end else if (sck_fall) begin
      miso_out    <= shift_reg[15];
      miso_oe_out <= ~shift_reg[15];
    end
  end

  // Decode of the last sixteen bits
  assign cmd         = spi_access_pkg::command_frame_t'(shift_reg);
  assign cmd_data    = cmd.data;
  assign parity_bad  = cmd.odd_check_bit != ~(^{cmd.write, cmd.addr, cmd.data});
  assign aligned     = got_frame & (rise_count == 4'h0);
  assign frame_err   = ~aligned | parity_bad | (~cmd.write & (cmd.data != spi_access_pkg::ZERO_BYTE));
  assign addr_listed = cmd.addr <= spi_access_pkg::ADDR_LAST;
  assign do_write    = decode_now & cmd.write & ~frame_err & addr_listed
                       & (cmd.addr != spi_access_pkg::ADDR_FAULT_ONE)
                       & (cmd.addr != spi_access_pkg::ADDR_FAULT_TWO);
  assign do_clear    = decode_now & ~cmd.write & ~frame_err;

  always_comb begin
    rd_data = spi_access_pkg::ZERO_BYTE;
    if (addr_listed) begin
      rd_data = regs[cmd.addr];
    end
  end

  always_comb begin
    rd_resp = '{serial_error_flag:         frame_err,
                pattern:                   spi_access_pkg::READ_PATTERN,
                timing_resistor_open_flag: regs[spi_access_pkg::ADDR_FAULT_ONE][spi_access_pkg::RESISTOR_OPEN_BIT],
                power_cycled_flag:         regs[spi_access_pkg::ADDR_FAULT_ONE][spi_access_pkg::POWER_CYCLED_BIT],
                thermal_warning_flag:      regs[spi_access_pkg::ADDR_FAULT_ONE][spi_access_pkg::THERMAL_WARN_BIT],
                data:                      rd_data};
    wr_resp = '{serial_error_flag: 1'b0, write: 1'b1, addr: cmd.addr, data: cmd.data};
    if (!got_frame) begin
      next_response = spi_access_pkg::ERROR_FRAME;
    end else if (cmd.write) begin
      next_response = frame_err ? spi_access_pkg::ERROR_FRAME : 16'(wr_resp);
    end else begin
      next_response = 16'(rd_resp);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      response              <= spi_access_pkg::ERROR_FRAME;
      serial_error_flag_out <= 1'b0;
    end else if (decode_now) begin
      response              <= next_response;
      serial_error_flag_out <= frame_err;
    end
  end

  // Hardware-set status: a set in the same cycle as a clear wins
  always_comb begin
    next_fault_one  = regs[spi_access_pkg::ADDR_FAULT_ONE];
    next_fault_two  = regs[spi_access_pkg::ADDR_FAULT_TWO];
    next_config_one = regs[spi_access_pkg::ADDR_CONFIG_ONE];
    if (do_clear && cmd.addr == spi_access_pkg::ADDR_FAULT_ONE) begin
      next_fault_one = spi_access_pkg::ZERO_BYTE;
    end
    if (do_clear && cmd.addr == spi_access_pkg::ADDR_FAULT_TWO) begin
      next_fault_two = spi_access_pkg::ZERO_BYTE;
    end
    next_fault_one = next_fault_one | (fault_set_one_in & spi_access_pkg::FAULT_ONE_SET_MASK);
    next_fault_two = next_fault_two | (fault_set_two_in & spi_access_pkg::FAULT_TWO_SET_MASK);
    if (do_write && cmd.addr == spi_access_pkg::ADDR_CONFIG_ONE) begin
      next_config_one = cmd.data;
      next_config_one[spi_access_pkg::LIMP_BIT] = cmd.data[spi_access_pkg::LIMP_BIT]
        & regs[spi_access_pkg::ADDR_CONFIG_ONE][spi_access_pkg::LIMP_BIT];
    end
    next_config_one[spi_access_pkg::LIMP_BIT] = next_config_one[spi_access_pkg::LIMP_BIT] | limp_pin_s;
  end

  // Register array
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < spi_access_pkg::REG_COUNT; i++) begin
        regs[i] <= spi_access_pkg::REG_DEFAULT[i];
      end
    end else begin
      if (do_write) begin
        regs[cmd.addr] <= cmd.data;
      end
      regs[spi_access_pkg::ADDR_CONFIG_ONE] <= next_config_one;
      regs[spi_access_pkg::ADDR_FAULT_ONE]  <= next_fault_one;
      regs[spi_access_pkg::ADDR_FAULT_TWO]  <= next_fault_two;
    end
  end

  // Limp mode selects the alternate enable set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      limp_home_status_out <= 1'b0;
      active_enable_out    <= spi_access_pkg::REG_DEFAULT[spi_access_pkg::ADDR_EN];
      channel_enable_out   <= 2'h0;
    end else begin
      limp_home_status_out <= regs[spi_access_pkg::ADDR_CONFIG_ONE][spi_access_pkg::LIMP_BIT];
      if (regs[spi_access_pkg::ADDR_CONFIG_ONE][spi_access_pkg::LIMP_BIT]) begin
        active_enable_out  <= regs[spi_access_pkg::ADDR_LIMP_EN];
        channel_enable_out <= regs[spi_access_pkg::ADDR_LIMP_EN][1:0];
      end else begin
        active_enable_out  <= regs[spi_access_pkg::ADDR_EN];
        channel_enable_out <= regs[spi_access_pkg::ADDR_EN][1:0];
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_sample_msb_first;
    sck_rise |=> shift_reg[0] == $past(mosi_s);
  endproperty
  a_sample_msb_first: assert property (p_sample_msb_first) else $error("host bit not shifted in");

  property p_first_bit_on_fall;
    sel_fall |=> miso_out == $past(response[15]) && miso_oe_out == !$past(response[15]);
  endproperty
  a_first_bit_on_fall: assert property (p_first_bit_on_fall) else $error("first bit not presented");

  property p_released_idle;
    pins.slave_select_low && $past(pins.slave_select_low) |-> !miso_oe_out;
  endproperty
  a_released_idle: assert property (p_released_idle) else $error("output driven while idle");

  property p_shift_out;
    sck_fall && !sel_rise |=> miso_out == $past(shift_reg[15]);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("output not updated on falling clock");

  property p_counter_cleared;
    sel_fall |=> rise_count == 4'h0 && !got_frame;
  endproperty
  a_counter_cleared: assert property (p_counter_cleared) else $error("bit counter not cleared");

  property p_abort_frame;
    decode_now && !got_frame |=> response == spi_access_pkg::ERROR_FRAME && serial_error_flag_out;
  endproperty
  a_abort_frame: assert property (p_abort_frame) else $error("short transfer not flagged");

  property p_misalign_error;
    decode_now && got_frame && rise_count != 4'h0 |-> !do_write ##1 serial_error_flag_out;
  endproperty
  a_misalign_error: assert property (p_misalign_error) else $error("misaligned transfer accepted");

  property p_parity_blocks_write;
    decode_now && parity_bad |-> !do_write ##1 response[15];
  endproperty
  a_parity_blocks_write: assert property (p_parity_blocks_write) else $error("bad parity write taken");

  property p_write_lands;
    do_write && cmd.addr == spi_access_pkg::ADDR_EN |=> regs[spi_access_pkg::ADDR_EN] == $past(cmd_data);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write did not land");

  property p_write_echo;
    decode_now && got_frame && cmd.write && !frame_err |=> response[15:14] == 2'h1
      && response[7:0] == $past(cmd_data);
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("write not echoed");

  property p_read_pattern;
    decode_now && got_frame && !cmd.write |=> response[14:11] == spi_access_pkg::READ_PATTERN;
  endproperty
  a_read_pattern: assert property (p_read_pattern) else $error("read response pattern wrong");

  property p_error_keeps_faults;
    decode_now && frame_err && !cmd.write && cmd.addr == spi_access_pkg::ADDR_FAULT_TWO |=>
      regs[spi_access_pkg::ADDR_FAULT_TWO] == ($past(regs[spi_access_pkg::ADDR_FAULT_TWO]) | $past(fault_set_two_in));
  endproperty
  a_error_keeps_faults: assert property (p_error_keeps_faults) else $error("errored read cleared faults");

  property p_limp_follows_pin;
    limp_pin_s |=> regs[spi_access_pkg::ADDR_CONFIG_ONE][spi_access_pkg::LIMP_BIT] ##1 limp_home_status_out;
  endproperty
  a_limp_follows_pin: assert property (p_limp_follows_pin) else $error("limp bit not set by pin");

endmodule // spi_register_access_port

// ==== verification/spi_host_model.sv ====
// Host-side serial master model that frames commands and collects responses
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic        clk_in,
  input  wire logic        miso_oe_in,
  output logic             ssel_low_out,
  output logic             sclk_out,
  output logic             mosi_out,
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_out
);
  logic line;

  // Open-drain output with pull-up
  assign line = miso_oe_in ? 1'b0 : 1'b1;

  initial begin
    ssel_low_out  = 1'b1;
    sclk_out      = 1'b0;
    mosi_out      = 1'b0;
    rsp_valid_out = 1'b0;
    rsp_out       = 16'h0000;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Sends bits[n-1:0] MSB first, keeps the first 16 returned bits
  task automatic frame(input logic [31:0] bits, input int n);
    logic [15:0] got;
    got = 16'h0000;
    wait_clk(1);
    ssel_low_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_out = bits[i];
      wait_clk(5);
      if (n - 1 - i < 16) got = {got[14:0], line};
      sclk_out = 1'b1;
      wait_clk(5);
      sclk_out = 1'b0;
    end
    wait_clk(5);
    ssel_low_out = 1'b1;
    mosi_out = ~mosi_out;
    rsp_out = got;
    rsp_valid_out = (n >= 16);
    wait_clk(1);
    rsp_valid_out = 1'b0;
    wait_clk(7);
  endtask
endmodule // spi_host_model

// ==== verification/tb_top.sv ====
// Self-checking testbench for the serial register access port
`timescale 1ns/1ps
module tb_top;
  logic        clk_in    = 1'b0;
  logic        rst_in    = 1'b1;
  logic        limp_pin  = 1'b0;
  logic [7:0]  fset1     = 8'h00;
  logic [7:0]  fset2     = 8'h00;
  logic        ssel_low;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        err_flag;
  logic        limp_stat;
  logic        rsp_valid;
  logic [7:0]  act_en;
  logic [1:0]  ch_en;
  logic [15:0] rsp;
  logic [15:0] exp_q [$];
  logic [7:0]  d1;
  logic [7:0]  d3;
  logic [7:0]  f2;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cycles    = 0;

  always #12.5 clk_in = ~clk_in;

  spi_register_access_port i_spi_register_access_port (
    .clk_in(clk_in), .rst_in(rst_in), .slave_select_low_in(ssel_low), .sclk_in(sclk),
    .mosi_in(mosi), .limp_home_pin_in(limp_pin), .fault_set_one_in(fset1),
    .fault_set_two_in(fset2), .miso_out(miso), .miso_oe_out(miso_oe),
    .serial_error_flag_out(err_flag), .limp_home_status_out(limp_stat),
    .active_enable_out(act_en), .channel_enable_out(ch_en));

  spi_host_model i_spi_host_model (
    .clk_in(clk_in), .miso_oe_in(miso_oe), .ssel_low_out(ssel_low), .sclk_out(sclk),
    .mosi_out(mosi), .rsp_valid_out(rsp_valid), .rsp_out(rsp));

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  function automatic logic [15:0] cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
    return {w, a, ~^{w, a, d}, d};
  endfunction

  task automatic xfer(input logic [31:0] v, input int n, input logic [15:0] want);
    if (n >= 16) exp_q.push_back(want);
    i_spi_host_model.frame(v, n);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  always @(posedge clk_in) begin
    if (rsp_valid === 1'b1) check(rsp, exp_q.pop_front(), "response");
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    void'($urandom(24));
    d1 = 8'($urandom());
    d3 = 8'($urandom());
    f2 = 8'($urandom()) | 8'h01;
    settle(4);
    rst_in = 1'b0;
    settle(4);
    check({15'h0, miso_oe}, 16'h0000, "idle release");
    check({8'h00, act_en}, 16'h003C, "enable default");
    check({14'h0, ch_en}, 16'h0000, "channels off");
    xfer(cmd(1'h0, 6'h11, 8'h00), 16, 16'h8000);
    xfer(cmd(1'h0, 6'h00, 8'h00), 16, 16'h6220);
    xfer(cmd(1'h1, 6'h00, d1), 16, 16'h603C);
    check({8'h00, act_en}, {8'h00, d1}, "enable write");
    check({14'h0, ch_en}, {14'h0, d1[1:0]}, "channels");
    check({15'h0, err_flag}, 16'h0000, "clean flag");
    xfer(32'h0, 0, 16'h0000);
    check({15'h0, err_flag}, 16'h0001, "no clock");
    xfer(cmd(1'h1, 6'h00, ~d1) ^ 16'h0100, 16, 16'h8000);
    check({8'h00, act_en}, {8'h00, d1}, "bad parity write");
    xfer(cmd(1'h0, 6'h00, 8'h5A), 16, 16'h8000);
    xfer(cmd(1'h0, 6'h00, 8'h00), 16, {8'hE0, d1});
    check({15'h0, err_flag}, 16'h0000, "clean read");
    fset2 = f2;
    settle(2);
    fset2 = 8'h00;
    xfer(32'h000000A5, 8, 16'h0000);
    check({15'h0, err_flag}, 16'h0001, "short frame");
    check({8'h00, act_en}, {8'h00, d1}, "aborted");
    xfer({15'h0, 1'h1, cmd(1'h0, 6'h12, 8'h00)}, 17, 16'h8000);
    xfer(cmd(1'h0, 6'h12, 8'h00), 16, {8'hE0, f2});
    xfer({cmd(1'h0, 6'h12, 8'h00), cmd(1'h1, 6'h00, d3)}, 32, {8'h60, f2});
    check({8'h00, act_en}, {8'h00, d3}, "long frame write");
    xfer(cmd(1'h0, 6'h12, 8'h00), 16, {8'h40, d3});
    fset1 = 8'h90;
    settle(2);
    fset1 = 8'h00;
    xfer(cmd(1'h0, 6'h11, 8'h00), 16, 16'h6000);
    limp_pin = 1'b1;
    settle(8);
    check({15'h0, limp_stat}, 16'h0001, "limp set");
    check({8'h00, act_en}, 16'h003C, "limp settings");
    xfer(cmd(1'h1, 6'h01, 8'h00), 16, 16'h6590);
    check({15'h0, limp_stat}, 16'h0001, "pin still high");
    limp_pin = 1'b0;
    settle(8);
    xfer(cmd(1'h1, 6'h01, 8'h10), 16, 16'h4100);
    check({15'h0, limp_stat}, 16'h0001, "write one");
    xfer(cmd(1'h1, 6'h01, 8'h00), 16, 16'h4110);
    check({15'h0, limp_stat}, 16'h0000, "limp left");
    check({8'h00, act_en}, {8'h00, d3}, "normal settings");
    xfer(cmd(1'h1, 6'h01, 8'h10), 16, 16'h4100);
    check({15'h0, limp_stat}, 16'h0000, "write one ignored");
    xfer(cmd(1'h0, 6'h3F, 8'h00), 16, 16'h4110);
    xfer(cmd(1'h0, 6'h00, 8'h00), 16, 16'h6000);
    check({14'h0, miso_oe, miso}, 16'h0001, "released");
    results();
  end
endmodule // tb_top
